/* File: logic/arx_map.svh */
// constants of the receiver output and interrupt settings block
// assumes a word-wide avalon slave where byte address = 4 * index
`ifndef ARX_MAP_SVH
`define ARX_MAP_SVH
`define ARX_IDX_SYS 8'he8
`define ARX_IDX_IO 8'he9
`define ARX_IDX_IRQ 8'hea
`define ARX_IDX_SRC 8'heb
`define ARX_IDX_RATE 8'hf0
`define ARX_IO_RESET 16'h0002
`define ARX_IRQ_RESET 16'h0000
`define ARX_SYS_RESET 16'h0000
`define ARX_SYSRST_BIT 0
`define ARX_RATE_SLOTS 6
`define ARX_ALL_RATES 6'h3f
`define ARX_PULSE_CYC 1
`define ARX_SRC_RATE 5
`define ARX_SRC_CS 6
`define ARX_SRC_SUBQ 7
`endif

/* File: logic/arx_pkg.sv */
// types of the receiver output and interrupt settings block
// assumes arx_map.svh supplies the numeric constants
package arx_pkg;
  typedef enum logic [1:0] {
    ARX_BUS_IDLE = 2'b01,
    ARX_BUS_ACK = 2'b10
  } arx_bus_t;
  typedef struct packed {
    logic rsv15;
    logic serial_out_mute;
    logic force_passthrough;
    logic unlock_output_select;
    logic rsv11;
    logic [2:0] output_format_select;
    logic [3:0] accepted_rate_select;
    logic rate_range_high;
    logic reception_limit_en;
    logic gp_pin_level;
    logic gp_pin_source_select;
  } arx_io_cfg_t;
  typedef struct packed {
    logic irq_en_subq_loaded;
    logic irq_en_status_update;
    logic irq_en_rate_update;
    logic irq_en_validity;
    logic irq_en_emphasis;
    logic irq_en_nonpcm_change;
    logic irq_en_error_change;
    logic emph_irq_pin_select;
    logic [6:0] rsv;
    logic irq_pulse_form;
  } arx_irq_cfg_t;
  // receiver status from the demodulator, same clock
  typedef struct packed {
    logic pll_locked;
    logic xmit_error;
    logic nonpcm_detect;
    logic emph_detect;
    logic validity_err;
    logic clk_switch_period;
    logic rate_meas_done;
    logic [2:0] rate_slot;
    logic cs_block_done;
    logic [47:0] cs_bits;
    logic subq_loaded;
  } arx_rx_status_t;
  // format steering for the serial output formatter
  typedef struct packed {
    logic [4:0] word_len;
    logic i2s;
    logic right_just;
    logic lsb_first;
    logic biphase;
  } arx_fmt_t;
  typedef struct packed {
    arx_bus_t bus;
    logic [15:0] readdata;
    logic [15:0] sys;
    arx_io_cfg_t io;
    arx_irq_cfg_t irq;
    logic [2:0] rate_slot;
    logic rate_known;
    logic [47:0] cs_prev;
    logic rate_upd;
    logic cs_upd;
    logic subq_det;
    logic err_q;
    logic pcm_q;
    logic [6:0] cond_q;
    logic irq_hold;
    logic [7:0] pulse_cnt;
    logic user_gp_pin;
    logic emph_irq_pin;
  } arx_state_t;
endpackage

/* File: logic/arx_sdo_sel.sv */
// serial data output selector
// assumes serial_data_in already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module arx_sdo_sel (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_out_mute,
  input wire logic force_passthrough,
  input wire logic unlock_output_select,
  input wire logic pll_locked,
  input wire logic serial_data_in,
  input wire logic demod_data,
  output logic serial_data_out
);
  logic next_out;

  always_comb begin
    if (serial_out_mute) begin
      next_out = 1'b0;
    end else if (force_passthrough) begin
      next_out = serial_data_in;
    end else if (!pll_locked) begin
      next_out = unlock_output_select ? 1'b0 : serial_data_in;
    end else begin
      next_out = demod_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= next_out;
    end
  end

  a_mute_wins: assert property (@(posedge clock) disable iff (!rst_n)
    serial_out_mute |=> !serial_data_out)
    else $error("muted output not low");
endmodule
`default_nettype wire

/* File: logic/arx_top.sv */
// output and interrupt settings of the audio receiver
// assumes an avalon-mm master on clock and demodulator status on clock
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "arx_map.svh"
module arx_top
  import arx_pkg::*;
#(
  parameter logic [7:0] PULSE_CYC = 8'(`ARX_PULSE_CYC)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire arx_rx_status_t rx_status,
  input wire logic demod_data,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic user_gp_pin,
  output logic emph_irq_pin,
  output logic error_out,
  output arx_fmt_t out_format,
  output logic rate_range_high,
  output logic soft_reset
);
  arx_state_t s;
  arx_state_t next_s;
  logic serial_data_in_meta;
  logic serial_data_in_sync;
  logic [7:0] idx;
  logic req;
  logic take;
  logic src_read;
  logic [5:0] acc_mask;
  logic rate_ok;
  logic err_now;
  logic rate_change;
  logic cs_same;
  logic [6:0] src_vec;
  logic [6:0] en_vec;
  logic [6:0] cond;
  logic irq_evt;
  logic irq_line;
  logic [15:0] src_word;

  //////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [5:0] rate_mask(input logic [3:0] sel);
    case (sel)
      4'h0: rate_mask = `ARX_ALL_RATES;
      4'h1: rate_mask = 6'h01;
      4'h2: rate_mask = 6'h02;
      4'h3: rate_mask = 6'h04;
      4'h4: rate_mask = 6'h10;
      4'h5: rate_mask = 6'h20;
      4'h6: rate_mask = 6'h12;
      4'h7: rate_mask = 6'h24;
      4'h8: rate_mask = 6'h07;
      default: rate_mask = `ARX_ALL_RATES;
    endcase
  endfunction

  function automatic arx_fmt_t fmt_decode(input logic [2:0] code);
    arx_fmt_t f;
    f = '0;
    case (code)
      3'h0: f.word_len = 5'd24;
      3'h1: begin
        f.word_len = 5'd24;
        f.i2s = 1'b1;
      end
      3'h2: begin
        f.word_len = 5'd24;
        f.right_just = 1'b1;
      end
      3'h3: begin
        f.word_len = 5'd20;
        f.right_just = 1'b1;
      end
      3'h4: begin
        f.word_len = 5'd16;
        f.right_just = 1'b1;
      end
      3'h5: f.biphase = 1'b1;
      3'h6: begin
        f.word_len = 5'd28;
        f.i2s = 1'b1;
      end
      default: begin
        f.word_len = 5'd28;
        f.lsb_first = 1'b1;
      end
    endcase
    return f;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_in_meta <= 1'b0;
      serial_data_in_sync <= 1'b0;
    end else begin
      serial_data_in_meta <= serial_data_in;
      serial_data_in_sync <= serial_data_in_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status and interrupt sources

  assign idx = address[9:2];
  assign req = read | write;
  assign take = req && s.bus == ARX_BUS_ACK;
  assign src_read = take && read && idx == `ARX_IDX_SRC;
  // reserved selections accept every rate in the span
  assign acc_mask = rate_mask(s.io.accepted_rate_select);
  assign rate_ok = !s.rate_known || acc_mask[s.rate_slot];
  assign err_now = rx_status.xmit_error || !rx_status.pll_locked ||
    (s.io.reception_limit_en && !rate_ok);
  assign rate_change = rx_status.rate_meas_done && rx_status.pll_locked &&
    (!s.rate_known || rx_status.rate_slot != s.rate_slot);
  assign cs_same = rx_status.cs_block_done &&
    rx_status.cs_bits == s.cs_prev;
  assign src_vec = {s.subq_det, s.cs_upd, s.rate_upd,
    rx_status.validity_err, rx_status.emph_detect,
    s.pcm_q != rx_status.nonpcm_detect, s.err_q != err_now};
  assign en_vec = {s.irq.irq_en_subq_loaded, s.irq.irq_en_status_update,
    s.irq.irq_en_rate_update, s.irq.irq_en_validity,
    s.irq.irq_en_emphasis, s.irq.irq_en_nonpcm_change,
    s.irq.irq_en_error_change};
  assign cond = src_vec & en_vec;
  assign irq_evt = |(cond & ~s.cond_q);
  assign irq_line = s.irq.irq_pulse_form ? (s.pulse_cnt != 8'h00)
    : s.irq_hold;
  assign src_word = {8'h00, s.subq_det, s.cs_upd, s.rate_upd,
    rx_status.validity_err, rx_status.emph_detect,
    rx_status.nonpcm_detect, err_now, 1'b0};

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.err_q = err_now;
    next_s.pcm_q = rx_status.nonpcm_detect;
    next_s.cond_q = cond;
    // bus: one wait state, then the request is taken
    case (s.bus)
      ARX_BUS_IDLE: begin
        if (req) begin
          next_s.bus = ARX_BUS_ACK;
          next_s.readdata = 16'h0000;
          if (read && idx == `ARX_IDX_SRC) begin
            next_s.readdata = src_word;
          end else if (read && idx == `ARX_IDX_SYS) begin
            next_s.readdata = s.sys;
          end else if (read && idx == `ARX_IDX_RATE) begin
            next_s.readdata = {12'h000, s.rate_known, s.rate_slot};
          end
        end
      end
      ARX_BUS_ACK: begin
        next_s.bus = ARX_BUS_IDLE;
        if (write && idx == `ARX_IDX_IO) begin
          next_s.io = writedata[15:0];
        end else if (write && idx == `ARX_IDX_IRQ) begin
          next_s.irq = writedata[15:0];
        end else if (write && idx == `ARX_IDX_SYS) begin
          next_s.sys = writedata[15:0];
        end
      end
      default: next_s.bus = ARX_BUS_IDLE;
    endcase
    // clear on read first, so a same-cycle set wins; only flags that the
    // answer carried are cleared, one raised in the wait state survives
    if (src_read) begin
      next_s.rate_upd = s.rate_upd && !s.readdata[`ARX_SRC_RATE];
      next_s.cs_upd = s.cs_upd && !s.readdata[`ARX_SRC_CS];
      next_s.subq_det = s.subq_det && !s.readdata[`ARX_SRC_SUBQ];
      next_s.irq_hold = 1'b0;
    end
    if (rx_status.rate_meas_done) begin
      next_s.rate_slot = rx_status.rate_slot;
      next_s.rate_known = 1'b1;
    end
    if (rx_status.cs_block_done) begin
      next_s.cs_prev = rx_status.cs_bits;
    end
    if (rate_change && s.rate_known) begin
      next_s.rate_upd = 1'b1;
    end
    if (cs_same) begin
      next_s.cs_upd = 1'b1;
    end
    if (rx_status.subq_loaded) begin
      next_s.subq_det = 1'b1;
    end
    if (irq_evt) begin
      // pulse mode leaves no level to resurface on a later mode switch
      next_s.irq_hold = s.irq_hold || !s.irq.irq_pulse_form;
      next_s.pulse_cnt = PULSE_CYC;
    end else if (s.pulse_cnt != 8'h00) begin
      next_s.pulse_cnt = s.pulse_cnt - 8'h01;
    end
    // soft reset clears the event flags, interrupt state, rate_known and cs_prev; command registers and rate_slot are kept
    if (s.sys[`ARX_SYSRST_BIT]) begin
      next_s.rate_known = 1'b0;
      next_s.cs_prev = '0;
      next_s.rate_upd = 1'b0;
      next_s.cs_upd = 1'b0;
      next_s.subq_det = 1'b0;
      next_s.irq_hold = 1'b0;
      next_s.pulse_cnt = 8'h00;
    end
    next_s.user_gp_pin = s.io.gp_pin_source_select ?
      rx_status.clk_switch_period : s.io.gp_pin_level;
    next_s.emph_irq_pin = s.irq.emph_irq_pin_select ?
      irq_line : rx_status.emph_detect;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.bus <= ARX_BUS_IDLE;
      s.io <= `ARX_IO_RESET;
      s.irq <= `ARX_IRQ_RESET;
      s.sys <= `ARX_SYS_RESET;
      s.user_gp_pin <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign waitrequest = req && s.bus != ARX_BUS_ACK;
  assign readdata = {16'h0000, s.readdata};
  assign user_gp_pin = s.user_gp_pin;
  assign emph_irq_pin = s.emph_irq_pin;
  assign error_out = s.err_q;
  assign out_format = fmt_decode(s.io.output_format_select);
  assign rate_range_high = s.io.rate_range_high;
  assign soft_reset = s.sys[`ARX_SYSRST_BIT];

  arx_sdo_sel u_sdo (
    .clock(clock),
    .rst_n(rst_n),
    .serial_out_mute(s.io.serial_out_mute),
    .force_passthrough(s.io.force_passthrough),
    .unlock_output_select(s.io.unlock_output_select),
    .pll_locked(rx_status.pll_locked),
    .serial_data_in(serial_data_in_sync),
    .demod_data(demod_data),
    .serial_data_out(serial_data_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence src_read_seq;
    req && read && idx == `ARX_IDX_SRC ##1 src_read;
  endsequence

  sequence evt_seq;
    irq_evt && !src_read && !s.sys[`ARX_SYSRST_BIT];
  endsequence

  a_gp_pin_src: assert property (
    s.io.gp_pin_source_select |=>
    user_gp_pin == $past(rx_status.clk_switch_period))
    else $error("gp pin not following switch period");

  a_error_flag: assert property (
    (rx_status.xmit_error || !rx_status.pll_locked) |=> error_out)
    else $error("error flag missed");

  a_limit_error: assert property (
    !s.io.reception_limit_en && rx_status.pll_locked &&
    !rx_status.xmit_error |=> !error_out)
    else $error("error without limit");

  a_hold_until_read: assert property (
    evt_seq ##0 !s.irq.irq_pulse_form ##1
    (!s.irq.irq_pulse_form && !src_read && !s.sys[`ARX_SYSRST_BIT])
    |=> s.irq_hold)
    else $error("held interrupt dropped");

  a_hold_release: assert property (
    src_read_seq ##0 !irq_evt && !s.sys[`ARX_SYSRST_BIT] |=> !s.irq_hold)
    else $error("held interrupt not released");

  a_pulse_width: assert property (
    evt_seq |=> s.pulse_cnt == PULSE_CYC)
    else $error("pulse width wrong");

  a_rate_lock: assert property (
    rx_status.rate_meas_done && !rx_status.pll_locked && !src_read &&
    !s.rate_upd |=> !s.rate_upd)
    else $error("rate flag set on lock error");

  a_cs_clear: assert property (
    src_read && s.readdata[`ARX_SRC_CS] && !cs_same &&
    !s.sys[`ARX_SYSRST_BIT] |=> !s.cs_upd)
    else $error("status flag not cleared");

  a_cs_equal: assert property (
    cs_same && !s.sys[`ARX_SYSRST_BIT] |=> s.cs_upd)
    else $error("status update missed");

  a_emph_route: assert property (
    !s.irq.emph_irq_pin_select ##1 !s.irq.emph_irq_pin_select |->
    emph_irq_pin == $past(rx_status.emph_detect))
    else $error("emphasis not routed");

  a_gp_pin_level: assert property (
    !s.io.gp_pin_source_select |=> user_gp_pin == $past(s.io.gp_pin_level))
    else $error("gp pin not showing level bit");

  a_rate_upd_set: assert property (
    rate_change && s.rate_known && !s.sys[`ARX_SYSRST_BIT] |=> s.rate_upd)
    else $error("rate update missed");

  a_subq_set: assert property (
    rx_status.subq_loaded && !s.sys[`ARX_SYSRST_BIT] |=> s.subq_det)
    else $error("sub-code flag missed");

  a_cs_kept: assert property (
    src_read && s.cs_upd && !s.readdata[`ARX_SRC_CS] &&
    !s.sys[`ARX_SYSRST_BIT] |=> s.cs_upd)
    else $error("unreported status flag lost");

  a_pulse_no_hold: assert property (
    evt_seq ##0 s.irq.irq_pulse_form && !s.irq_hold |=> !s.irq_hold)
    else $error("pulse mode left a held level");

  a_bus_wait: assert property (
    req && s.bus == ARX_BUS_IDLE |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait");
endmodule
`default_nettype wire

/* File: test/arx_host.sv */
// host model: avalon-mm master making one access per go request
// assumes the slave answers by dropping waitrequest on clock
`timescale 1ns/1ps
`default_nettype none
module arx_host (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] idx,
  input wire logic [15:0] wd,
  output logic done,
  output logic [15:0] rd,
  output logic [9:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  logic busy;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rd <= 16'h0000;
      address <= 10'h000;
      read <= 1'b0;
      write <= 1'b0;
      writedata <= 32'h0000_0000;
    end else if (!busy && go) begin
      busy <= 1'b1;
      done <= 1'b0;
      address <= {idx, 2'b00};
      read <= !wr;
      write <= wr;
      writedata <= {16'h0000, wd};
    end else if (busy && !waitrequest) begin
      // a taken read of the source register frees a held interrupt
      rd <= readdata[15:0];
      busy <= 1'b0;
      done <= 1'b1;
      read <= 1'b0;
      write <= 1'b0;
      writedata <= ~writedata;
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench of the receiver output and interrupt settings
// assumes arx_top, the host model arx_host and one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "arx_map.svh"
module testbench
  import arx_pkg::*;
;
  typedef struct packed {
    logic [15:0] io;
    logic lk;
    logic si;
    logic dm;
    logic sdo;
    logic gp;
  } arx_tb_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rd;
  logic [15:0] m;
  logic done, read, write, waitrequest;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  arx_rx_status_t rx = '0;
  logic demod_data = 1'b0;
  logic serial_data_in = 1'b0;
  logic serial_data_out, user_gp_pin, emph_irq_pin, error_out;
  logic rate_range_high, soft_reset;
  arx_fmt_t out_format;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  arx_tb_row_t rows [8] = '{
    '{16'h0002, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{16'h1003, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{16'h3002, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1},
    '{16'h200a, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
    '{16'h6002, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
    '{16'h4002, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{16'h0002, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1}
  };
  // {word_len, i2s, right_just, lsb_first, biphase} per format code
  logic [8:0] fmt_exp [8] = '{9'h180, 9'h188, 9'h184, 9'h144,
    9'h104, 9'h001, 9'h1c8, 9'h1c2};

  always #12.5 clock = ~clock;

  arx_top #(.PULSE_CYC(8'h02)) arx_top_inst (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rx_status(rx), .demod_data(demod_data),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .user_gp_pin(user_gp_pin), .emph_irq_pin(emph_irq_pin),
    .error_out(error_out), .out_format(out_format),
    .rate_range_high(rate_range_high), .soft_reset(soft_reset)
  );
  arx_host arx_host_inst (
    .clock(clock), .rst_n(rst_n), .go(go), .wr(wr), .idx(idx), .wd(wd),
    .done(done), .rd(rd), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i,
                     input logic [15:0] d);
    go <= 1'b1;
    wr <= w;
    idx <= i;
    wd <= d;
    @(posedge clock);
    go <= 1'b0;
    do @(posedge clock); while (done !== 1'b1);
  endtask
  task automatic meas(input logic [2:0] s);
    rx.rate_slot <= s;
    rx.rate_meas_done <= 1'b1;
    @(posedge clock);
    rx.rate_meas_done <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic cs_blk(input logic [47:0] v);
    rx.cs_bits <= v;
    rx.cs_block_done <= 1'b1;
    @(posedge clock);
    rx.cs_block_done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic kick(input int b, input logic v);
    case (b)
      0: rx.nonpcm_detect <= v;
      1: rx.emph_detect <= v;
      default: rx.validity_err <= v;
    endcase
  endtask
  task automatic count_hi(input string nm, input int e);
    n = 0;
    repeat (12) begin
      @(posedge clock);
      if (emph_irq_pin === 1'b1) n++;
    end
    chk(nm, 16'(e), 16'(n));
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[k]) begin
      acc(1'b1, `ARX_IDX_IO, rows[k].io);
      rx.pll_locked <= rows[k].lk;
      serial_data_in <= rows[k].si;
      demod_data <= rows[k].dm;
      repeat (6) @(posedge clock);
      chk("sdo", 16'(rows[k].sdo), 16'(serial_data_out));
      chk("gp", 16'(rows[k].gp), 16'(user_gp_pin));
      chk("err", 16'(!rows[k].lk), 16'(error_out));
      chk("range", 16'(rows[k].io[3]), 16'(rate_range_high));
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, `ARX_IDX_IO, 16'h0002 | 16'(c << 8));
      m = (c == 5) ? 16'h000f : 16'h01ff;
      repeat (2) @(posedge clock);
      chk("fmt", 16'(fmt_exp[c]) & m, 16'(out_format) & m);
    end
    $display("test table done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk("gp_rst", 16'h0001, 16'(user_gp_pin));
    chk("fmt_rst", 16'h0180, 16'(out_format));
    rst_n <= 1'b1;
    @(posedge clock);
    acc(1'b0, `ARX_IDX_IO, 16'h0000);
    chk("io_read", 16'h0000, rd);
    acc(1'b1, 8'h10, 16'hffff);
    acc(1'b0, 8'h10, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    rx.emph_detect <= 1'b1;
    repeat (4) @(posedge clock);
    chk("emph_pin", 16'h0001, 16'(emph_irq_pin));
    rx.emph_detect <= 1'b0;
    $display("test reset done");
    rx.pll_locked <= 1'b1;
    acc(1'b1, `ARX_IDX_IO, 16'h0016);
    meas(3'h1);
    chk("limit_out", 16'h0001, 16'(error_out));
    meas(3'h0);
    chk("limit_in", 16'h0000, 16'(error_out));
    acc(1'b1, `ARX_IDX_IO, 16'h0002);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    meas(3'h1);
    meas(3'h0);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("rate_upd", 16'h0020, rd);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("rate_clr", 16'h0000, rd);
    rx.pll_locked <= 1'b0;
    meas(3'h1);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("rate_unlock", 16'h0002, rd);
    acc(1'b0, `ARX_IDX_RATE, 16'h0000);
    chk("rate_stat", 16'h0009, rd);
    acc(1'b1, `ARX_IDX_SYS, 16'h0001);
    chk("soft_on", 16'h0001, 16'(soft_reset));
    acc(1'b0, `ARX_IDX_SYS, 16'h0000);
    chk("sys_read", 16'h0001, rd);
    acc(1'b0, `ARX_IDX_RATE, 16'h0000);
    chk("rate_soft", 16'h0001, rd);
    acc(1'b1, `ARX_IDX_SYS, 16'h0000);
    chk("soft_off", 16'h0000, 16'(soft_reset));
    rx.pll_locked <= 1'b1;
    $display("test rate done");
    acc(1'b1, `ARX_IDX_IRQ, 16'h0300);
    rx.pll_locked <= 1'b0;
    repeat (24) @(posedge clock);
    chk("irq_held", 16'h0001, 16'(emph_irq_pin));
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("src_err", 16'h0002, rd);
    repeat (3) @(posedge clock);
    chk("irq_free", 16'h0000, 16'(emph_irq_pin));
    acc(1'b1, `ARX_IDX_IRQ, 16'h0100);
    rx.pll_locked <= 1'b1;
    repeat (4) @(posedge clock);
    chk("irq_off", 16'h0000, 16'(emph_irq_pin));
    acc(1'b1, `ARX_IDX_IRQ, 16'h8101);
    rx.subq_loaded <= 1'b1;
    @(posedge clock);
    rx.subq_loaded <= 1'b0;
    count_hi("subq_pulse", 2);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("subq_src", 16'h0080, rd);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("subq_clr", 16'h0000, rd);
    for (int b = 0; b < 3; b++) begin
      acc(1'b1, `ARX_IDX_IRQ, 16'h0101 | 16'(16'h0400 << b));
      kick(b, 1'b1);
      count_hi("src_pulse", 2);
      acc(1'b1, `ARX_IDX_IRQ, 16'h0100);
      kick(b, 1'b0);
    end
    $display("test interrupt done");
    acc(1'b1, `ARX_IDX_IRQ, 16'h4100);
    repeat (2) @(posedge clock);
    chk("irq_quiet", 16'h0000, 16'(emph_irq_pin));
    cs_blk(48'h1234_5678_9abc);
    cs_blk(48'h1234_5678_9abc);
    repeat (2) @(posedge clock);
    chk("cs_irq", 16'h0001, 16'(emph_irq_pin));
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("cs_src", 16'h0040, rd);
    cs_blk(48'h0000_0000_0001);
    acc(1'b0, `ARX_IDX_SRC, 16'h0000);
    chk("cs_diff", 16'h0000, rd);
    $display("test status done");
    close_out();
  end
endmodule
`default_nettype wire
